// ### rtl/sxaux_top.v
// Brake sequencing, area signals and motion parameter processing
`timescale 1ns/1ps
`include "sxaux_defines.vh"
module sxaux_top (
    input wire clk,
    input wire arst_n,
    input wire servo_on_req,
    input wire power_ok,
    input wire [15:0] brake_on_delay,
    input wire [15:0] brake_off_adv,
    input wire signed [31:0] motor_pos,
    input wire motor_is_linear,
    input wire [31:0] rated_vel,
    input wire [31:0] motor_res,
    input wire par_reset,
    input wire power_up,
    input wire hold_on,
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire [31:0] wr_data,
    input wire [3:0] rd_idx,
    input wire scale_wr,
    input wire [31:0] scale_cmd_new,
    input wire [31:0] scale_pls_new,
    input wire coord_linear_new,
    output reg servo_active_q,
    output reg brake_contact_a_q,
    output reg brake_contact_b_q,
    output reg [1:0] area_status_q,
    output reg [1:0] plc_area_q,
    output reg [31:0] rd_data_q,
    output reg [31:0] maxv_mon_q,
    output reg [31:0] scale_cmd_q,
    output reg [31:0] scale_pls_q,
    output reg coord_linear_q,
    output reg out_of_range_q,
    output reg checksum_err_q,
    output reg busy_q
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Bit 0 servo on request, bit 1 power present
    wire [1:0] pin_raw = {power_ok, servo_on_req};
    wire [1:0] pin_flt;
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_sync
            reg [2:0] sync_q;
            reg flt_q;
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    sync_q <= 3'h0;
                    flt_q <= 1'b0;
                end else begin
                    sync_q <= {sync_q[1:0], pin_raw[p]};
                    // Level taken once the last two stages agree
                    if (sync_q[2] == sync_q[1])
                        flt_q <= sync_q[2];
                end
            end
            assign pin_flt[p] = flt_q;
        end
    endgenerate

    wire svo_flt = pin_flt[0];
    wire pwr_flt = pin_flt[1];
    wire svo_req = svo_flt & pwr_flt;

    // ------------------------------------------------------------
    // Brake sequencer
    // ------------------------------------------------------------
    localparam BS_OFF = 2'h0;
    localparam BS_REL_WAIT = 2'h1;
    localparam BS_ON = 2'h2;
    localparam BS_ENG_WAIT = 2'h3;
    reg [1:0] bs_q;
    reg [15:0] bcnt_q;
    reg brake_rel_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bs_q <= BS_OFF;
            bcnt_q <= 16'h0000;
            brake_rel_q <= 1'b0;
            servo_active_q <= 1'b0;
        end else if (!pwr_flt) begin
            bs_q <= BS_OFF;
            brake_rel_q <= 1'b0;
            servo_active_q <= 1'b0;
            bcnt_q <= 16'h0000;
        end else begin
            case (bs_q)
                BS_OFF: begin
                    if (svo_req) begin
                        servo_active_q <= 1'b1;
                        bcnt_q <= brake_on_delay;
                        bs_q <= BS_REL_WAIT;
                    end
                end
                BS_REL_WAIT: begin
                    if (!svo_req) begin
                        brake_rel_q <= 1'b0;
                        bcnt_q <= brake_off_adv;
                        bs_q <= BS_ENG_WAIT;
                    end else if (bcnt_q == 16'h0000) begin
                        brake_rel_q <= 1'b1;
                        bs_q <= BS_ON;
                    end else
                        bcnt_q <= bcnt_q - 16'h0001;
                end
                BS_ON: begin
                    if (!svo_req) begin
                        brake_rel_q <= 1'b0;
                        bcnt_q <= brake_off_adv;
                        bs_q <= BS_ENG_WAIT;
                    end
                end
                BS_ENG_WAIT: begin
                    if (bcnt_q == 16'h0000) begin
                        servo_active_q <= 1'b0;
                        bs_q <= BS_OFF;
                    end else
                        bcnt_q <= bcnt_q - 16'h0001;
                end
                default: bs_q <= BS_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Brake contact outputs
    // ------------------------------------------------------------
    // Both contacts close together and open at once on power loss
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            brake_contact_a_q <= 1'b0;
            brake_contact_b_q <= 1'b0;
        end else begin
            brake_contact_a_q <= brake_rel_q & pwr_flt;
            brake_contact_b_q <= brake_rel_q & pwr_flt;
        end
    end

    // ------------------------------------------------------------
    // Parameter store
    // ------------------------------------------------------------
    reg [31:0] par_q [0:15];

    // ------------------------------------------------------------
    // Power-up limits
    // ------------------------------------------------------------
    // Max velocity in pulses per second
    wire [63:0] maxp_prod = par_q[`SXAUX_P_MAXV] * scale_pls_q;
    wire [63:0] maxp_full = (scale_cmd_q == 32'h0) ? 64'h0 : maxp_prod / scale_cmd_q;
    // Ceiling for max velocity and the velocity settings
    wire [31:0] maxv_lim = (par_q[`SXAUX_P_MAXV] > `SXAUX_MAXV_CMD) ? `SXAUX_MAXV_CMD :
        par_q[`SXAUX_P_MAXV];

    // ------------------------------------------------------------
    // Entry check
    // ------------------------------------------------------------
    wire is_vel = (wr_idx <= `SXAUX_P_OFS);
    wire skip_chk = hold_on | busy_q | scale_wr | (wr_idx == `SXAUX_P_MAXV);
    wire wr_bad = wr_en & is_vel & ~skip_chk & (wr_data > maxv_mon_q);

    // ------------------------------------------------------------
    // Scale conversion
    // ------------------------------------------------------------
    function [31:0] conv;
        input [31:0] v;
        input [31:0] n_pls;
        input [31:0] o_pls;
        reg [63:0] t;
        reg [63:0] q;
        begin
            t = v * n_pls;
            // Zero old ratio keeps the value
            q = (o_pls == 32'h0) ? {32'h0, v} : t / o_pls;
            conv = q[31:0];
        end
    endfunction
    function signed [31:0] sconv;
        input signed [31:0] v;
        input [31:0] n_pls;
        input [31:0] o_pls;
        reg [31:0] m;
        begin
            m = v[31] ? (32'h0 - v) : v;
            m = conv(m, n_pls, o_pls);
            sconv = v[31] ? (32'h0 - m) : m;
        end
    endfunction

    // ------------------------------------------------------------
    // Parameter update
    // ------------------------------------------------------------
    integer i;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 16; i = i + 1)
                par_q[i] <= 32'h0;
            scale_cmd_q <= 32'h1;
            scale_pls_q <= 32'h1;
            coord_linear_q <= 1'b0;
            maxv_mon_q <= 32'h0;
            busy_q <= 1'b0;
            out_of_range_q <= 1'b0;
            checksum_err_q <= 1'b0;
        end else if (par_reset) begin
            // Units equal pulses once scaling equals resolution
            par_q[`SXAUX_P_FEED] <= rated_vel;
            par_q[`SXAUX_P_JOG] <= rated_vel;
            par_q[`SXAUX_P_MAXV] <= rated_vel;
            par_q[`SXAUX_P_OTS] <= rated_vel / 32'd10;
            par_q[`SXAUX_P_PRX] <= rated_vel / 32'd10;
            par_q[`SXAUX_P_OFS] <= rated_vel / 32'd10;
            par_q[`SXAUX_P_TEST] <= rated_vel / 32'd500;
            par_q[`SXAUX_P_TUNE] <= rated_vel / 32'd50;
            scale_cmd_q <= motor_res;
            scale_pls_q <= motor_res;
            coord_linear_q <= motor_is_linear;
            maxv_mon_q <= rated_vel;
            out_of_range_q <= 1'b0;
            checksum_err_q <= 1'b0;
        end else if (scale_wr) begin
            // Values in command units follow the ratio of new to old command scaling
            for (i = 0; i < 15; i = i + 1)
                par_q[i] <= conv(par_q[i], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_HOME] <= sconv(par_q[`SXAUX_P_HOME], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_SLP] <= sconv(par_q[`SXAUX_P_SLP], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_SLN] <= sconv(par_q[`SXAUX_P_SLN], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_A0ON] <= sconv(par_q[`SXAUX_P_A0ON], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_A0OFF] <= sconv(par_q[`SXAUX_P_A0OFF], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_A1ON] <= sconv(par_q[`SXAUX_P_A1ON], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_A1OFF] <= sconv(par_q[`SXAUX_P_A1OFF], scale_cmd_new, scale_cmd_q);
            par_q[`SXAUX_P_MAXV] <= conv(par_q[`SXAUX_P_MAXV], scale_cmd_new, scale_cmd_q);
            if (coord_linear_new != coord_linear_q) begin
                par_q[`SXAUX_P_A0ON] <= 32'h0;
                par_q[`SXAUX_P_A0OFF] <= 32'h0;
                par_q[`SXAUX_P_A1ON] <= 32'h0;
                par_q[`SXAUX_P_A1OFF] <= 32'h0;
            end
            scale_cmd_q <= scale_cmd_new;
            scale_pls_q <= scale_pls_new;
            coord_linear_q <= coord_linear_new;
            busy_q <= 1'b1;
        end else if (power_up && busy_q) begin
            if (par_q[`SXAUX_P_MAXV] > `SXAUX_MAXV_CMD) begin
                par_q[`SXAUX_P_MAXV] <= `SXAUX_MAXV_CMD;
                maxv_mon_q <= `SXAUX_MAXV_CMD;
            end else
                maxv_mon_q <= par_q[`SXAUX_P_MAXV];
            if (maxp_full > {32'h0, `SXAUX_MAXV_PLS})
                checksum_err_q <= 1'b1;
            for (i = 0; i < 5; i = i + 1)
                if (par_q[i] > maxv_lim)
                    par_q[i] <= maxv_lim;
            busy_q <= 1'b0;
        end else if (wr_en) begin
            out_of_range_q <= wr_bad;
            if (!wr_bad)
                par_q[wr_idx] <= wr_data;
            if (wr_idx == `SXAUX_P_MAXV)
                busy_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Area signals
    // ------------------------------------------------------------
    wire [1:0] area_d;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_area
            wire signed [31:0] a_on = par_q[`SXAUX_P_A0ON + 2 * g];
            wire signed [31:0] a_off = par_q[`SXAUX_P_A0OFF + 2 * g];
            // On below off gives a window, on above off a wrap-around
            wire in_fwd = (motor_pos >= a_on) && (motor_pos < a_off);
            wire in_wrap = (motor_pos >= a_on) || (motor_pos < a_off);
            assign area_d[g] = (a_on < a_off) ? in_fwd :
                (a_on > a_off) ? in_wrap : 1'b0;
        end
    endgenerate
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            area_status_q <= 2'h0;
            plc_area_q <= 2'h0;
        end else begin
            area_status_q <= area_d;
            plc_area_q <= area_d;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rd_data_q <= 32'h0;
        else
            rd_data_q <= par_q[rd_idx];
    end
endmodule

// ### rtl/sxaux_defines.vh
// Constants for the servo auxiliary signal and parameter check block
// Summary of operation
// - Brake contact open while brake holds, incl. power loss and servo off.
// - Brake release delayed after servo on; brake engaged ahead of servo off.
// - Two area channels, each with own on and off coordinate.
// - Area pattern chosen by relative size of on and off coordinates.
// - Area states shown on status monitor and on controller outputs.
// - Parameter reset: feed, jog, max velocity rated; search velocities rated*0.1.
// - Parameter reset: test width rated*0.002, tuning width rated*0.02.
// - Parameter reset: scaling terms get resolution; coordinate type from motor type.
// - Power-up after scaling change clamps max velocity to 9999999 units/s.
// - Power-up after scaling change flags checksum error above 8000000 pls/s.
// - Scaling change reconverts velocities, offsets, widths, limits, areas, max.
// - Coordinate type change at a scaling write clears all four area coordinates.
// - Velocity written above max velocity monitor is out of range.
// - Entry check skipped in hold-on and during scaling or max change.
// - Power-up after scaling or max change clamps velocities to max monitor.
`ifndef SXAUX_DEFINES_VH
`define SXAUX_DEFINES_VH
`define SXAUX_W 32
`define SXAUX_DLY_W 16
`define SXAUX_MAXV_CMD 32'h0098967F
`define SXAUX_MAXV_PLS 32'h007A1200
`define SXAUX_NPAR 16
`define SXAUX_P_FEED 4'h0
`define SXAUX_P_JOG 4'h1
`define SXAUX_P_OTS 4'h2
`define SXAUX_P_PRX 4'h3
`define SXAUX_P_OFS 4'h4
`define SXAUX_P_HOME 4'h5
`define SXAUX_P_TEST 4'h6
`define SXAUX_P_TUNE 4'h7
`define SXAUX_P_SETL 4'h8
`define SXAUX_P_SLP 4'h9
`define SXAUX_P_SLN 4'hA
`define SXAUX_P_A0ON 4'hB
`define SXAUX_P_A0OFF 4'hC
`define SXAUX_P_A1ON 4'hD
`define SXAUX_P_A1OFF 4'hE
`define SXAUX_P_MAXV 4'hF
`endif

// ### bench/sxaux_checker.sv
// Concurrent checks on the servo auxiliary block ports
`timescale 1ns/1ps
module sxaux_checker (
    input wire clk,
    input wire arst_n,
    input wire power_ok,
    input wire par_reset,
    input wire power_up,
    input wire hold_on,
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire [31:0] wr_data,
    input wire scale_wr,
    input wire [31:0] rated_vel,
    input wire servo_active_q,
    input wire brake_contact_a_q,
    input wire [1:0] area_status_q,
    input wire [1:0] plc_area_q,
    input wire [31:0] maxv_mon_q,
    input wire out_of_range_q,
    input wire checksum_err_q,
    input wire busy_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Plain velocity write, nothing of higher priority in the same cycle
    wire wr_plain = wr_en && !par_reset && !scale_wr && !busy_q && !hold_on;
    property p_hold; !power_ok [*8] |-> !brake_contact_a_q && !servo_active_q; endproperty
    a_hold: assert property (p_hold) else $error("brake released without power");
    property p_rel; $rose(brake_contact_a_q) |-> $past(servo_active_q); endproperty
    a_rel: assert property (p_rel) else $error("brake released before servo on");
    property p_plc; plc_area_q == area_status_q; endproperty
    a_plc: assert property (p_plc) else $error("controller area differs");
    property p_def; par_reset |=> maxv_mon_q == $past(rated_vel) && !checksum_err_q; endproperty
    a_def: assert property (p_def) else $error("default max velocity wrong");
    property p_oor;
        wr_plain && wr_idx <= 4'h4 && wr_data > maxv_mon_q |=> out_of_range_q; endproperty
    a_oor: assert property (p_oor) else $error("excess velocity accepted");
    property p_skip;
        wr_en && hold_on && !par_reset && !scale_wr && !power_up |=> !out_of_range_q; endproperty
    a_skip: assert property (p_skip) else $error("check made in hold-on");
    property p_busy; scale_wr && !par_reset |=> busy_q; endproperty
    a_busy: assert property (p_busy) else $error("scaling change not pending");
    property p_clamp; power_up && busy_q && !par_reset && !scale_wr
        |=> !busy_q && maxv_mon_q <= 32'h0098967F; endproperty
    a_clamp: assert property (p_clamp) else $error("max velocity not clamped");
    property p_stick; checksum_err_q && !par_reset |=> checksum_err_q; endproperty
    a_stick: assert property (p_stick) else $error("checksum error lost");
    c_rel: cover property ($rose(brake_contact_a_q));
    c_oor: cover property (out_of_range_q);
    c_chk: cover property (checksum_err_q);
endmodule
bind sxaux_top sxaux_checker u_chk (.*);

// ### bench/sxaux_partner.sv
// Far side: brake relay coil and controller input latch
`timescale 1ns/1ps
module sxaux_partner (
    input wire clk,
    input wire contact_a,
    input wire contact_b,
    input wire [1:0] plc_in,
    output logic brake_released,
    output logic [1:0] plc_seen
);
    assign brake_released = contact_a & contact_b;
    always @(posedge clk) plc_seen <= plc_in;
endmodule

// ### bench/test_servo_aux_signals_param_check.sv
// Self-checking bench for the servo auxiliary block
`timescale 1ns/1ps
module test_servo_aux_signals_param_check;
    logic clk = 1'h0, arst_n = 1'h0, servo_on_req = 1'h0, power_ok = 1'h0;
    logic motor_is_linear = 1'h0, par_reset = 1'h0, power_up = 1'h0, hold_on = 1'h0;
    logic wr_en = 1'h0, scale_wr = 1'h0, coord_linear_new = 1'h0, brake_released;
    logic servo_active_q, brake_contact_a_q, brake_contact_b_q, coord_linear_q;
    logic out_of_range_q, checksum_err_q, busy_q;
    logic [15:0] brake_on_delay = 16'hA, brake_off_adv = 16'h6;
    logic signed [31:0] motor_pos = 32'sh0;
    logic [31:0] rated_vel = 32'h3E8, motor_res = 32'h10000, wr_data = 32'h0;
    logic [31:0] scale_cmd_new = 32'h0, scale_pls_new = 32'h0;
    logic [31:0] rd_data_q, maxv_mon_q, scale_cmd_q, scale_pls_q;
    logic [3:0] wr_idx = 4'h0, rd_idx = 4'h0;
    logic [1:0] area_status_q, plc_area_q, plc_seen;
    int fails = 0, checks_done = 0, n;
    sxaux_top uut (.*);
    sxaux_partner u_far (.clk(clk), .contact_a(brake_contact_a_q), .contact_b(brake_contact_b_q),
        .plc_in(plc_area_q), .brake_released(brake_released), .plc_seen(plc_seen));
    always #2.5 clk = ~clk;
    task automatic step(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // k: 2 parameter reset, 1 scaling write, 0 power-up
    task automatic pulse(input int k);
        {par_reset, scale_wr, power_up} = 3'h1 << k;
        step();
        {par_reset, scale_wr, power_up} = 3'h0;
        step();
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        wr_idx = idx;
        wr_data = d;
        wr_en = 1'h1;
        step();
        wr_en = 1'h0;
        step();
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        rd_idx = idx;
        step();
        check(rd_data_q, exp);
    endtask
    task automatic wait_brk(input logic want);
        n = 0;
        while (brake_released !== want && n < 40) begin
            step();
            n++;
        end
    endtask
    logic [3:0] dix [8] = '{4'h0, 4'h1, 4'hF, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
    logic [31:0] dval [8] = '{32'h3E8, 32'h3E8, 32'h3E8, 32'h64, 32'h64, 32'h64, 32'h2, 32'h14};
    task automatic t_defaults();
        pulse(2);
        check(maxv_mon_q, 32'h3E8);
        check(scale_cmd_q, motor_res);
        check(scale_pls_q, motor_res);
        check(coord_linear_q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rd(dix[i], dval[i]);
        end
    endtask
    task automatic t_entry();
        wr(4'h0, 32'h3E9);
        check(out_of_range_q, 32'h1);
        rd(4'h0, 32'h3E8);
        wr(4'h0, 32'h3E8);
        check(out_of_range_q, 32'h0);
        hold_on = 1'h1;
        wr(4'h1, 32'h7D0);
        hold_on = 1'h0;
        check(out_of_range_q, 32'h0);
        rd(4'h1, 32'h7D0);
    endtask
    logic signed [31:0] apos [5] = '{-32'sh5, 32'shA, 32'shF, 32'sh14, 32'sh19};
    logic [1:0] aexp [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h2};
    task automatic t_area();
        wr(4'hB, 32'hA);
        wr(4'hC, 32'h14);
        wr(4'hD, 32'h14);
        wr(4'hE, 32'hA);
        for (int i = 0; i < 5; i++) begin
            motor_pos = apos[i];
            step(2);
            check(area_status_q, aexp[i]);
            check(plc_seen, aexp[i]);
        end
    endtask
    task automatic t_brake();
        power_ok = 1'h1;
        servo_on_req = 1'h1;
        step(14);
        check(brake_released, 32'h0);
        wait_brk(1'h1);
        check(brake_released, 32'h1);
        servo_on_req = 1'h0;
        wait_brk(1'h0);
        step(4);
        check(servo_active_q, 32'h1);
        step(6);
        check(servo_active_q, 32'h0);
        servo_on_req = 1'h1;
        wait_brk(1'h1);
        power_ok = 1'h0;
        step(8);
        check({brake_released, servo_active_q}, 32'h0);
    endtask
    task automatic t_scale();
        coord_linear_new = 1'h1;
        scale_cmd_new = 32'h20000;
        scale_pls_new = 32'h10000;
        pulse(1);
        check(busy_q, 32'h1);
        rd(4'hB, 32'h0);
        rd(4'h1, 32'hFA0);
        wr(4'h0, 32'h1F40);
        check(out_of_range_q, 32'h0);
        pulse(0);
        check(maxv_mon_q, 32'h7D0);
        rd(4'h1, 32'h7D0);
        rd(4'h0, 32'h7D0);
        check(checksum_err_q, 32'h0);
        hold_on = 1'h1;
        wr(4'hF, 32'h989680);
        hold_on = 1'h0;
        scale_pls_new = 32'h80000;
        pulse(1);
        pulse(0);
        check(maxv_mon_q, 32'h98967F);
        check(checksum_err_q, 32'h1);
        pulse(2);
        check(checksum_err_q, 32'h0);
        motor_is_linear = 1'h1;
        pulse(2);
        check(coord_linear_q, 32'h1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        step(20);
        arst_n = 1'h1;
        step(4);
        t_defaults();
        t_entry();
        t_area();
        t_brake();
        t_scale();
        print_verdict();
    end
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
endmodule
